// >>> core/table_flash_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

// Table read/write path, holding registers and unlocked row erase / block program
module table_flash_sequencer #(
    parameter int unsigned LONG_WRITE_CYCLES = flash_table_pkg::LONG_WRITE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    // Special function register port
    input wire logic [2:0] sfr_select,
    input wire logic sfr_write,
    input wire logic sfr_read,
    input wire logic [7:0] sfr_write_data,
    output logic [7:0] sfr_read_data,
    // Table instruction request from the core
    input wire logic table_op_valid,
    input wire logic table_op_write,
    input wire logic [1:0] table_op_mode,
    output logic table_op_done,
    // Program and configuration memory read port
    output logic [19:0] flash_read_word_addr,
    output logic flash_read_config,
    input wire logic [15:0] flash_read_word,
    // Long write commands to the array
    output logic flash_erase_start,
    output logic [15:0] flash_row_addr,
    output logic flash_program_start,
    output logic [18:0] flash_block_addr,
    output logic [63:0] flash_program_data,
    // Core stall and completion flag
    output logic core_stall,
    output logic write_done_flag,
    input wire logic write_done_clear
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        flash_table_pkg::seq_state_t state; // Sequencer state
        logic [7:0] table_byte_latch; // Byte moved by table ops
        logic [21:0] table_pointer; // Upper:high:low joined
        logic program_memory_select; // Program flash vs data memory
        logic config_space_select; // Configuration space access
        logic row_erase_enable; // Next start erases a row
        logic write_enable_bit; // Erase and write allowed
        logic start; // Long write requested / running
        logic [1:0] unlock_stage; // 0 none, 1 saw first, 2 armed
        logic [7:0][7:0] holding; // Eight programming holding bytes
        logic [19:0] read_word_addr; // Word address sent to memory
        logic read_config; // Read targets configuration space
        logic read_high_byte; // Byte select for pending read
        logic erase_start; // One-cycle erase command
        logic program_start; // One-cycle program command
        logic [15:0] row_addr; // Row being erased
        logic [18:0] block_addr; // Block being programmed
        logic [63:0] program_data; // Snapshot of holding bytes
        logic done_flag; // Sticky completion flag
        logic [7:0] read_data; // Registered register read
    } seq_t;

    seq_t cur;
    seq_t next_cur;
    logic timer_start;
    logic timer_expired;
    logic op_taken;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Apply an automatic update; the top bit never moves
    function automatic logic [21:0] step_pointer(input logic [21:0] p, input logic [1:0] mode);
        logic [20:0] low;
        low = p[20:0];
        case (mode)
            flash_table_pkg::MODE_POST_INC,
            flash_table_pkg::MODE_PRE_INC: low = p[20:0] + 21'h000001;
            flash_table_pkg::MODE_POST_DEC: low = p[20:0] - 21'h000001;
            default: low = p[20:0];
        endcase
        return {p[21], low};
    endfunction : step_pointer

    // Address actually used by the access; only pre-increment moves it first
    function automatic logic [21:0] access_pointer(input logic [21:0] p, input logic [1:0] mode);
        if (mode == flash_table_pkg::MODE_PRE_INC)
            return step_pointer(p, mode);
        else
            return p;
    endfunction : access_pointer

    // ----------------------------------------------------------------
    // Programming timer
    // ----------------------------------------------------------------
    program_timer #(
        .CYCLES(LONG_WRITE_CYCLES)
    ) u_timer (
        .clock(clock),
        .rst(rst),
        .start(timer_start),
        .expired(timer_expired)
    );

    // Timer starts with either long write command
    assign timer_start = cur.erase_start | cur.program_start;

    // Table request accepted only while idle and not stalled
    assign op_taken = table_op_valid && (cur.state == flash_table_pkg::ST_IDLE);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [21:0] eff;
        logic start_attempt;
        logic start_ok;
        eff = access_pointer(cur.table_pointer, table_op_mode);
        start_attempt = 1'b0;
        start_ok = 1'b0;
        next_cur = cur;
        next_cur.erase_start = 1'b0;
        next_cur.program_start = 1'b0;

        // Register writes from the core
        if (sfr_write)
        begin
            case (sfr_select)
                flash_table_pkg::SEL_LATCH: next_cur.table_byte_latch = sfr_write_data;
                flash_table_pkg::SEL_POINTER_LOW: next_cur.table_pointer[7:0] = sfr_write_data;
                flash_table_pkg::SEL_POINTER_HIGH: next_cur.table_pointer[15:8] = sfr_write_data;
                flash_table_pkg::SEL_POINTER_UPPER: next_cur.table_pointer[21:16] = sfr_write_data[5:0];
                flash_table_pkg::SEL_UNLOCK:
                begin
                    // Nothing stored; only the sequence position moves
                    if (sfr_write_data == flash_table_pkg::UNLOCK_FIRST)
                        next_cur.unlock_stage = 2'h1;
                    else if (sfr_write_data == flash_table_pkg::UNLOCK_SECOND && cur.unlock_stage == 2'h1)
                        next_cur.unlock_stage = 2'h2;
                    else
                        next_cur.unlock_stage = 2'h0;
                end
                flash_table_pkg::SEL_CONTROL:
                begin
                    next_cur.program_memory_select = sfr_write_data[flash_table_pkg::BIT_PROGRAM_SELECT];
                    next_cur.config_space_select = sfr_write_data[flash_table_pkg::BIT_CONFIG_SELECT];
                    next_cur.write_enable_bit = sfr_write_data[flash_table_pkg::BIT_WRITE_ENABLE];
                    // Erase select cannot change under a running erase
                    if (!cur.start)
                        next_cur.row_erase_enable = sfr_write_data[flash_table_pkg::BIT_ROW_ERASE];
                    start_attempt = sfr_write_data[flash_table_pkg::BIT_START] && !cur.start;
                    // Start needs enable, flash target, and a fresh unlock
                    start_ok = start_attempt && cur.write_enable_bit
                        && sfr_write_data[flash_table_pkg::BIT_WRITE_ENABLE]
                        && cur.unlock_stage == 2'h2
                        && sfr_write_data[flash_table_pkg::BIT_PROGRAM_SELECT]
                        && !sfr_write_data[flash_table_pkg::BIT_CONFIG_SELECT];
                    // Any start attempt uses up the unlock, good or not
                    if (start_attempt)
                        next_cur.unlock_stage = 2'h0;
                    if (start_ok)
                    begin
                        next_cur.start = 1'b1;
                        next_cur.state = flash_table_pkg::ST_LONG;
                        if (sfr_write_data[flash_table_pkg::BIT_ROW_ERASE])
                        begin
                            // Whole row only; the latch plays no part
                            next_cur.erase_start = 1'b1;
                            next_cur.row_addr = cur.table_pointer[21:6];
                        end
                        else
                        begin
                            next_cur.program_start = 1'b1;
                            next_cur.block_addr = cur.table_pointer[21:3];
                            next_cur.program_data = cur.holding;
                        end
                    end
                end
                default: ; // Unused selects ignore writes
            endcase
        end

        // Register reads; data appears one cycle after the strobe
        if (sfr_read)
        begin
            case (sfr_select)
                flash_table_pkg::SEL_LATCH: next_cur.read_data = cur.table_byte_latch;
                flash_table_pkg::SEL_POINTER_LOW: next_cur.read_data = cur.table_pointer[7:0];
                flash_table_pkg::SEL_POINTER_HIGH: next_cur.read_data = cur.table_pointer[15:8];
                flash_table_pkg::SEL_POINTER_UPPER: next_cur.read_data = {2'h0, cur.table_pointer[21:16]};
                flash_table_pkg::SEL_CONTROL:
                    next_cur.read_data = {cur.program_memory_select, cur.config_space_select, 1'b0,
                        cur.row_erase_enable, 1'b0, cur.write_enable_bit, cur.start, 1'b0};
                default: next_cur.read_data = 8'h00;
            endcase
        end

        // Table instructions; they follow register writes in the same cycle
        case (cur.state)
            flash_table_pkg::ST_IDLE:
            begin
                if (op_taken)
                begin
                    next_cur.table_pointer = step_pointer(cur.table_pointer, table_op_mode);
                    if (table_op_write)
                    begin
                        next_cur.holding[eff[2:0]] = cur.table_byte_latch;
                    end
                    else
                    begin
                        // Word address, space and byte select from all 22 bits
                        next_cur.read_word_addr = eff[20:1];
                        next_cur.read_config = eff[21];
                        next_cur.read_high_byte = eff[0];
                        next_cur.state = flash_table_pkg::ST_READ;
                    end
                end
            end
            flash_table_pkg::ST_READ:
            begin
                // Memory answers the registered address within this cycle
                next_cur.table_byte_latch = cur.read_high_byte ? flash_read_word[15:8]
                    : flash_read_word[7:0];
                next_cur.state = flash_table_pkg::ST_IDLE;
            end
            flash_table_pkg::ST_LONG:
            begin
                // Only the timer ends the stall
                if (timer_expired)
                begin
                    next_cur.state = flash_table_pkg::ST_IDLE;
                    next_cur.start = 1'b0;
                    next_cur.row_erase_enable = 1'b0;
                    next_cur.done_flag = 1'b1;
                end
            end
            default: next_cur.state = flash_table_pkg::ST_IDLE;
        endcase

        // Software clear loses to a completion in the same cycle
        if (write_done_clear && !(cur.state == flash_table_pkg::ST_LONG && timer_expired))
            next_cur.done_flag = 1'b0;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.state <= flash_table_pkg::ST_IDLE;
            cur.table_byte_latch <= flash_table_pkg::RESET_BYTE;
            cur.table_pointer <= flash_table_pkg::RESET_POINTER;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Writes finish when taken, reads in the capture cycle
    assign table_op_done = (op_taken && table_op_write) || (cur.state == flash_table_pkg::ST_READ);
    assign sfr_read_data = cur.read_data;
    assign flash_read_word_addr = cur.read_word_addr;
    assign flash_read_config = cur.read_config;
    assign flash_erase_start = cur.erase_start;
    assign flash_row_addr = cur.row_addr;
    assign flash_program_start = cur.program_start;
    assign flash_block_addr = cur.block_addr;
    assign flash_program_data = cur.program_data;
    assign core_stall = (cur.state == flash_table_pkg::ST_LONG);
    assign write_done_flag = cur.done_flag;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_UNLOCK_READS_ZERO: assert property (@(posedge clock) disable iff (rst)
        sfr_read && sfr_select == flash_table_pkg::SEL_UNLOCK |=> sfr_read_data == 8'h00)
        else $error("unlock port read was not zero");

    AST_START_NEEDS_ENABLE: assert property (@(posedge clock) disable iff (rst)
        sfr_write && sfr_select == flash_table_pkg::SEL_CONTROL && !cur.write_enable_bit && !cur.start
        |=> !cur.start && !core_stall)
        else $error("start accepted with write enable clear");

    AST_START_NEEDS_UNLOCK: assert property (@(posedge clock) disable iff (rst)
        sfr_write && sfr_select == flash_table_pkg::SEL_CONTROL && cur.unlock_stage != 2'h2
        |=> !flash_erase_start && !flash_program_start)
        else $error("long write began without unlock");

    AST_STALL_WITH_ERASE: assert property (@(posedge clock) disable iff (rst)
        flash_erase_start |-> core_stall ##1 core_stall[*8])
        else $error("core not stalled during erase");

    AST_COMPLETION: assert property (@(posedge clock) disable iff (rst)
        $fell(core_stall) |-> write_done_flag && !cur.start && !cur.row_erase_enable)
        else $error("completion did not set flag and clear start");

    AST_TOP_BIT_KEPT: assert property (@(posedge clock) disable iff (rst)
        op_taken && !sfr_write |=> cur.table_pointer[21] == $past(cur.table_pointer[21]))
        else $error("automatic update changed top pointer bit");

    AST_POST_DEC: assert property (@(posedge clock) disable iff (rst)
        op_taken && !sfr_write && table_op_mode == flash_table_pkg::MODE_POST_DEC
        |=> cur.table_pointer[20:0] == $past(cur.table_pointer[20:0]) - 21'h000001)
        else $error("post-decrement wrong");

    AST_READ_BYTE: assert property (@(posedge clock) disable iff (rst)
        cur.state == flash_table_pkg::ST_READ |=> cur.table_byte_latch ==
        ($past(cur.read_high_byte) ? $past(flash_read_word[15:8]) : $past(flash_read_word[7:0])))
        else $error("table read latched wrong byte");

    AST_ROW_ADDR: assert property (@(posedge clock) disable iff (rst)
        flash_erase_start |-> flash_row_addr == $past(cur.table_pointer[21:6]))
        else $error("erase row address wrong");

    AST_HOLDING_WRITE: assert property (@(posedge clock) disable iff (rst)
        op_taken && table_op_write && table_op_mode == flash_table_pkg::MODE_HOLD
        |=> cur.holding[$past(cur.table_pointer[2:0])] == $past(cur.table_byte_latch))
        else $error("holding register not loaded");

    AST_BLOCK_SNAPSHOT: assert property (@(posedge clock) disable iff (rst)
        flash_program_start |-> flash_block_addr == $past(cur.table_pointer[21:3])
        && flash_program_data == $past(cur.holding))
        else $error("program block address or data wrong");

    AST_DONE_SET_WINS: assert property (@(posedge clock) disable iff (rst)
        cur.state == flash_table_pkg::ST_LONG && timer_expired |=> write_done_flag)
        else $error("completion did not set done flag");

    AST_DONE_STICKY: assert property (@(posedge clock) disable iff (rst)
        write_done_flag && !write_done_clear |=> write_done_flag)
        else $error("done flag dropped without clear");

    AST_NO_TABLE_OP_WHILE_STALLED: assert property (@(posedge clock) disable iff (rst)
        core_stall |-> !table_op_done)
        else $error("table instruction finished during stall");

endmodule : table_flash_sequencer

`default_nettype wire

// >>> pkg/flash_table_pkg.sv

`default_nettype none

package flash_table_pkg;

    // ----------------------------------------------------------------
    // Register selects on the special function register port
    // ----------------------------------------------------------------
    localparam logic [2:0] SEL_LATCH = 3'h0;
    localparam logic [2:0] SEL_POINTER_LOW = 3'h1;
    localparam logic [2:0] SEL_POINTER_HIGH = 3'h2;
    localparam logic [2:0] SEL_POINTER_UPPER = 3'h3;
    localparam logic [2:0] SEL_CONTROL = 3'h4;
    localparam logic [2:0] SEL_UNLOCK = 3'h5;

    // ----------------------------------------------------------------
    // Memory control register bit positions
    // ----------------------------------------------------------------
    localparam int BIT_PROGRAM_SELECT = 7;
    localparam int BIT_CONFIG_SELECT = 6;
    localparam int BIT_ROW_ERASE = 4;
    localparam int BIT_WRITE_ENABLE = 2;
    localparam int BIT_START = 1;

    // ----------------------------------------------------------------
    // Unlock values and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [21:0] RESET_POINTER = 22'h000000;

    // ----------------------------------------------------------------
    // Long write timing
    // ----------------------------------------------------------------
    localparam int LONG_WRITE_TIME_US = 2000;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int LONG_WRITE_CYCLES = LONG_WRITE_TIME_US * 1000 / CLOCK_PERIOD_NS;
    localparam int TIMER_WIDTH = 24;

    // ----------------------------------------------------------------
    // Pointer modes carried by each table instruction
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_HOLD = 2'b00,
        MODE_POST_INC = 2'b01,
        MODE_POST_DEC = 2'b10,
        MODE_PRE_INC = 2'b11
    } pointer_mode_t;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_LONG = 2'b10
    } seq_state_t;

endpackage : flash_table_pkg

`default_nettype wire

// >>> core/program_timer.sv
`timescale 1ns/1ns
`default_nettype none

// Self-timed long write interval; one pulse when the interval is over
module program_timer #(
    parameter int unsigned CYCLES = flash_table_pkg::LONG_WRITE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    output logic expired
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic running; // Interval in progress
        logic [flash_table_pkg::TIMER_WIDTH-1:0] count; // Cycles elapsed
        logic expired; // Registered end pulse
    } timer_t;

    timer_t cur;
    timer_t next_cur;

    localparam logic [flash_table_pkg::TIMER_WIDTH-1:0] LAST =
        flash_table_pkg::TIMER_WIDTH'(CYCLES - 1);

    // Count from start; a start while running restarts nothing
    always_comb
    begin
        next_cur = cur;
        next_cur.expired = 1'b0;
        if (cur.running)
        begin
            if (cur.count == LAST)
            begin
                next_cur.running = 1'b0;
                next_cur.expired = 1'b1;
            end
            else
            begin
                next_cur.count = cur.count + 1'b1;
            end
        end
        else if (start)
        begin
            next_cur.running = 1'b1;
            next_cur.count = '0;
        end
    end

    // Register the state
    always_ff @(posedge clock)
    begin
        if (rst)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign expired = cur.expired;

endmodule : program_timer

`default_nettype wire

// >>> testbench/flash_array_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Program memory array behind the read port
// ----------------------------------------
module flash_array_model (
    input wire logic [19:0] flash_read_word_addr,
    input wire logic flash_read_config,
    output logic [15:0] flash_read_word
);
    // Word follows its own address so every byte lane is distinct; config space marks the high byte
    assign flash_read_word = {flash_read_config ? 8'hC3 : ~flash_read_word_addr[7:0], flash_read_word_addr[7:0]};
endmodule : flash_array_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // ----------------------------------------
    // Signals and scoreboard
    // ----------------------------------------
    localparam int LWC = 20; // Short timer keeps the run brief
    localparam logic [2:0] LAT = flash_table_pkg::SEL_LATCH;
    localparam logic [2:0] CTL = flash_table_pkg::SEL_CONTROL;
    localparam logic [2:0] UNL = flash_table_pkg::SEL_UNLOCK;
    logic clock = 1'b0, rst = 1'b1, sfr_write = 1'b0, sfr_read = 1'b0, write_done_clear = 1'b0;
    logic [2:0] sfr_select = 3'h0;
    logic [7:0] sfr_write_data = 8'h00, sfr_read_data, rd;
    logic table_op_valid = 1'b0, table_op_write = 1'b0, table_op_done, flash_read_config;
    logic [1:0] table_op_mode = 2'h0;
    logic [19:0] flash_read_word_addr;
    logic [15:0] flash_read_word, flash_row_addr, row;
    logic flash_erase_start, flash_program_start, core_stall, write_done_flag;
    logic [18:0] flash_block_addr, blk;
    logic [63:0] flash_program_data, dat, ed;
    logic [21:0] p, a;
    int failures = 0, tests_run = 0, erases = 0, progs = 0, n;
    table_flash_sequencer #(.LONG_WRITE_CYCLES(LWC)) table_flash_sequencer_i (.clock, .rst, .sfr_select,
        .sfr_write, .sfr_read, .sfr_write_data, .sfr_read_data, .table_op_valid, .table_op_write,
        .table_op_mode, .table_op_done, .flash_read_word_addr, .flash_read_config, .flash_read_word,
        .flash_erase_start, .flash_row_addr, .flash_program_start, .flash_block_addr,
        .flash_program_data, .core_stall, .write_done_flag, .write_done_clear);
    flash_array_model flash_array_model_i (.flash_read_word_addr, .flash_read_config, .flash_read_word);
    always #5 clock = ~clock;
    // Capture each start pulse with its address and data
    always @(posedge clock)
    begin
        if (flash_erase_start === 1'b1)
        begin
            erases++;
            row = flash_row_addr;
        end
        if (flash_program_start === 1'b1)
        begin
            progs++;
            blk = flash_block_addr;
            dat = flash_program_data;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge clock);
        sfr_select <= s;
        sfr_write_data <= d;
        sfr_write <= 1'b1;
        @(posedge clock);
        sfr_write <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [2:0] s);
        @(posedge clock);
        sfr_select <= s;
        sfr_read <= 1'b1;
        @(posedge clock);
        sfr_read <= 1'b0;
        @(negedge clock);
        rd = sfr_read_data;
    endtask : rdr
    task automatic set_ptr(input logic [21:0] v);
        wr(3'h3, {2'h0, v[21:16]});
        wr(3'h2, v[15:8]);
        wr(3'h1, v[7:0]);
    endtask : set_ptr
    task automatic chk_ptr(input logic [21:0] v);
        logic [23:0] got;
        rdr(3'h3);
        got[23:16] = rd;
        rdr(3'h2);
        got[15:8] = rd;
        rdr(3'h1);
        got[7:0] = rd;
        check(got, {2'h0, v});
    endtask : chk_ptr
    task automatic top(input logic w, input logic [1:0] m);
        @(posedge clock);
        table_op_valid <= 1'b1;
        table_op_write <= w;
        table_op_mode <= m;
        for (n = 0; n < 20; n++)
        begin
            @(negedge clock);
            if (table_op_done === 1'b1)
                break;
        end
        if (n == 20)
        begin
            failures++;
            tally_and_finish();
        end
        @(posedge clock);
        table_op_valid <= 1'b0;
    endtask : top
    // Unlock pair then start attempt; n counts the stalled cycles that follow
    task automatic lw(input logic [7:0] first, input logic [7:0] ctl);
        wr(UNL, first);
        wr(UNL, 8'hAA);
        wr(CTL, ctl);
        @(posedge clock);
        for (n = 0; n < 100; n++)
        begin
            @(negedge clock);
            if (core_stall !== 1'b1)
                break;
        end
        if (n == 100)
        begin
            failures++;
            tally_and_finish();
        end
    endtask : lw
    function automatic logic [7:0] eb(input logic [21:0] x);
        return x[0] ? (x[21] ? 8'hC3 : ~x[8:1]) : x[8:1];
    endfunction : eb
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (int s = 0; s < 6; s++)
        begin
            rdr(3'(s));
            check(rd, 8'h00);
        end
        wr(UNL, 8'h55);
        rdr(UNL);
        check(rd, 8'h00);
        set_ptr(22'h3FFFFF);
        wr(3'h3, 8'hFF);
        top(1'b0, flash_table_pkg::MODE_POST_INC);
        rdr(LAT);
        check(rd, eb(22'h3FFFFF));
        chk_ptr(22'h200000);
        top(1'b0, flash_table_pkg::MODE_POST_DEC);
        chk_ptr(22'h3FFFFF);
        for (int m = 0; m < 4; m++)
        begin
            p = 22'h0000A0 + 22'(m);
            set_ptr(p);
            top(1'b0, 2'(m));
            a = (m == 3) ? p + 22'h1 : p;
            rdr(LAT);
            check(rd, eb(a));
            chk_ptr((m == 0) ? p : (m == 2) ? p - 22'h1 : p + 22'h1);
        end
        set_ptr(22'h0001A5);
        wr(LAT, 8'hEE);
        top(1'b1, flash_table_pkg::MODE_HOLD);
        chk_ptr(22'h0001A5);
        for (int i = 0; i < 8; i++)
        begin
            wr(LAT, 8'h30 + 8'(i));
            ed[8 * ((5 + i) % 8) +: 8] = 8'h30 + 8'(i);
            top(1'b1, flash_table_pkg::MODE_POST_INC);
        end
        wr(CTL, 8'h84);
        lw(8'h55, 8'h86);
        check(progs, 64'h1);
        check(blk, 64'h35);
        check(dat, ed);
        check(n >= LWC && n <= LWC + 4, 1'b1);
        check(write_done_flag, 1'b1);
        rdr(CTL);
        check(rd, 8'h84);
        @(posedge clock);
        write_done_clear <= 1'b1;
        @(posedge clock);
        write_done_clear <= 1'b0;
        @(negedge clock);
        check(write_done_flag, 1'b0);
        set_ptr(22'h00017F);
        wr(LAT, 8'h5A);
        wr(CTL, 8'h94);
        lw(8'h55, 8'h96);
        check({erases[7:0], row}, {8'h1, 16'h0005});
        check(n >= LWC, 1'b1);
        wr(CTL, 8'h80);
        lw(8'h55, 8'h96);
        check({erases[7:0], n[7:0]}, {8'h1, 8'h0});
        rdr(CTL);
        check(rd[1], 1'b0);
        wr(CTL, 8'h84);
        lw(8'h12, 8'h86);
        check({progs[7:0], n[7:0]}, {8'h1, 8'h0});
        tally_and_finish();
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
